/* hdl/bic_regs.svh */
// Constants for the busy and interrupt pin control block
`ifndef BIC_REGS_SVH
`define BIC_REGS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define BIC_CLK_MHZ        40
`define BIC_COLD_US        3500
`define BIC_WARM_US        340
`define BIC_CRYSTAL_OSCILLATOR_US        31
`define BIC_COLD_CYC       (`BIC_COLD_US * `BIC_CLK_MHZ)
`define BIC_WARM_CYC       (`BIC_WARM_US * `BIC_CLK_MHZ)
`define BIC_CRYSTAL_OSCILLATOR_CYC       (18'(`BIC_CRYSTAL_OSCILLATOR_US * `BIC_CLK_MHZ))
`define BIC_CMD_CYC        18'h00004
`define BIC_SVC_CYC        4'h8
`define BIC_TMR_ZERO       18'h00000

// ****************************************************************
// Command opcodes (first byte of a frame)
// ****************************************************************
`define BIC_OP_READ_FLAGS  8'h10
`define BIC_OP_CLEAR_FLAGS 8'h11
`define BIC_OP_MASK_MAP    8'h12
`define BIC_OP_RFSW_EN     8'h13
`define BIC_OP_REFOSC_EN   8'h14
`define BIC_OP_SLEEP       8'h15
`define BIC_OP_STANDBY     8'h16
`define BIC_OP_FSYNTH      8'h17
`define BIC_OP_TX          8'h18
`define BIC_OP_RX          8'h19

// ****************************************************************
// Frame layout and field positions
// ****************************************************************
`define BIC_FRAME_BYTES    9
`define BIC_FLAG_W         10
`define BIC_FLAG_HI_W      2
`define BIC_SLEEP_WARM_BIT 2
`define BIC_STBY_CRYSTAL_OSCILLATOR_BIT  0
`define BIC_ENABLE_BIT     0
`define BIC_FLAGS_RESET    10'h000

// ****************************************************************
// Status flag bit positions
// ****************************************************************
`define BIC_IRQ_TX_DONE    0
`define BIC_IRQ_RX_DONE    1
`define BIC_IRQ_PREAMBLE   2
`define BIC_IRQ_SYNC_OK    3
`define BIC_IRQ_HDR_OK     4
`define BIC_IRQ_HDR_FAIL   5
`define BIC_IRQ_CRC_FAIL   6
`define BIC_IRQ_SCAN_DONE  7
`define BIC_IRQ_ACT_FOUND  8
`define BIC_IRQ_TIMEOUT    9

`endif

/* hdl/bic_pkg.sv */
// Types shared by the busy and interrupt pin control block
package bic_pkg;
   typedef logic [7:0]  bic_byte_t;   // One frame byte
   typedef logic [9:0]  bic_flags_t;  // One bit per interrupt source
   typedef logic [17:0] bic_tmr_t;    // Busy hold timer
   // Chip operating modes
   typedef enum logic [2:0] {
      md_startup,
      md_sleep,
      md_stby_rc,
      md_stby_crystal_oscillator,
      md_fsynth,
      md_rx,
      md_tx
   } bic_mode_e;
endpackage

/* hdl/bic_spi_link.sv */
// Serial link front end running on the host's shift clock
`timescale 1ns/1ps
`include "bic_regs.svh"

module bic_spi_link (
   input  wire logic                sck,          // Host shift clock
   input  wire logic                nss_n,        // Frame select, low in frame
   input  wire logic                mosi,         // Host data in
   input  wire bic_pkg::bic_flags_t status_snap,  // Flags, frozen during frames
   output logic [71:0]              frame_bytes,  // Received bytes, byte 0 low
   output logic [3:0]               frame_len,    // Bytes in last frame
   output logic                     miso_out,     // Reply data
   output logic                     miso_oe_n     // Reply drive, low = driving
);
   import bic_pkg::*;

   // ****************************************************************
   // Receive side
   // ****************************************************************
   logic [2:0]  bit_cnt_r;                 // Bit within byte
   logic [3:0]  byte_idx_r;                // Byte within frame
   logic [6:0]  shift_r;                   // Partial byte
   bic_flags_t  snap_meta_r;               // First sync stage
   bic_flags_t  snap_sync_r;               // Second sync stage
   bic_byte_t   reply;                     // Byte being answered

   // Counters cleared by the frame select itself, since sck stops outside frames
   always_ff @(posedge sck or posedge nss_n) begin
      if (nss_n) begin
         bit_cnt_r  <= 3'h0;
         byte_idx_r <= 4'h0;
      end else begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         // Saturate so overlong frames cannot wrap
         if (bit_cnt_r == 3'h7 && byte_idx_r != 4'(`BIC_FRAME_BYTES)) begin
            byte_idx_r <= byte_idx_r + 4'h1;
         end
      end
   end

   // Byte storage stays put after the frame so the core can read it
   always_ff @(posedge sck) begin
      shift_r <= {shift_r[5:0], mosi};
      if (bit_cnt_r == 3'h7 && byte_idx_r != 4'(`BIC_FRAME_BYTES)) begin
         frame_bytes[byte_idx_r*8 +: 8] <= {shift_r, mosi};
         frame_len                      <= byte_idx_r + 4'h1;
      end
   end

   // Status crosses by two flops; it is long settled before byte 1
   always_ff @(posedge sck) begin
      snap_meta_r <= status_snap;
      snap_sync_r <= snap_meta_r;
   end

   // ****************************************************************
   // Reply side
   // ****************************************************************
   always_comb begin
      reply = 8'h00;
      // Only a flag read returns data; byte 0 always answers zero
      if (byte_idx_r != 4'h0 && frame_bytes[7:0] == `BIC_OP_READ_FLAGS) begin
         if (byte_idx_r == 4'h1) begin
            reply = {6'h00, snap_sync_r[`BIC_FLAG_W-1:8]};
         end else if (byte_idx_r == 4'h2) begin
            reply = snap_sync_r[7:0];
         end
      end
   end

   // Reply launched on the falling edge, released as soon as the frame ends
   always_ff @(negedge sck or posedge nss_n) begin
      if (nss_n) begin
         miso_out  <= 1'b0;
         miso_oe_n <= 1'b1;
      end else begin
         miso_out  <= reply[3'h7 - bit_cnt_r];
         miso_oe_n <= 1'b0;
      end
   end
endmodule // bic_spi_link

/* hdl/bic_busy_irq_ctrl.sv */
// Busy line, mode sequencing and interrupt pin routing of the radio
// Operation
// - Busy low only when idle, ready for commands
// - Busy falls only once mode is stable
// - Write commands raise busy within 600 ns
// - Read commands never raise busy
// - Busy high in sleep, low after leaving
// - Synthesis mode busy until PLL lock
// - Receive mode busy until receiver ready
// - Transmit mode busy until ramp done
// - Internal interrupt servicing raises busy unprompted
// - Sleep wake busy 3500 us cold, 340 warm
// - Switch time measured select rise to busy fall
// - Any pin interrupts; read and clear flags
// - RF switch pin high only in transmit
// - Reference oscillator supply switched automatically
// - Ten sources, each masked, routed per pin
// - Fixed status bit positions zero to nine
// - Pins float in reset, startup, sleep
// - Seven operating modes supported
// - Wake on select low or timer
// - Busy high after reset until boot
`timescale 1ns/1ps
`include "bic_regs.svh"

module bic_busy_irq_ctrl #(
   parameter int unsigned COLD_START_CYC = `BIC_COLD_CYC,  // Cold wake busy time
   parameter int unsigned WARM_START_CYC = `BIC_WARM_CYC   // Warm wake busy time
) (
   input  wire logic                clk,                      // Core clock, 40 MHz
   input  wire logic                reset,                    // Synchronous, active high
   input  wire logic                sck,                      // Host shift clock
   input  wire logic                nss_n,                    // Frame select pin
   input  wire logic                mosi,                     // Host data pin
   input  wire bic_pkg::bic_flags_t event_pulse,              // Radio events, one cycle
   input  wire logic                pll_locked,               // Synthesizer locked
   input  wire logic                rx_ready,                 // Receiver up
   input  wire logic                pa_ramp_done,             // Amplifier ramped
   input  wire logic                wake_timer_eoc,           // Wake timer end of count
   output logic                     miso_out,                 // Reply data pin
   output logic                     miso_oe_n,                // Reply drive, low = driving
   output logic                     busy_out,                 // Busy pin level
   output logic                     busy_oe_n,                // Busy drive, low = driving
   output logic                     irq_pin_primary_out,      // Pin 1 level
   output logic                     irq_pin_primary_oe_n,     // Pin 1 drive
   output logic                     irq_or_rfswitch_pin_out,  // Pin 2 level
   output logic                     irq_or_rfswitch_pin_oe_n, // Pin 2 drive
   output logic                     irq_or_refosc_pin_out,    // Pin 3 level
   output logic                     irq_or_refosc_pin_oe_n,   // Pin 3 drive
   output bic_pkg::bic_mode_e       chip_mode                 // Current mode
);
   import bic_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [71:0] frame_bytes;               // Last frame from the link
   logic [3:0]  frame_len;                 // Its byte count
   logic        nss_meta_r;                // Select sync, first stage
   logic        nss_sync_r;                // Select sync, second stage
   logic        nss_prev_r;                // For edge detection
   logic        frame_start;               // Select fell
   logic        frame_end;                 // Select rose
   bic_byte_t   opcode;                    // Byte 0 of the frame
   logic        cmd_valid;                 // Frame usable as a command
   logic        cmd_write;                 // Command needs the state machine
   bic_mode_e   mode_r;                    // Operating mode
   bic_tmr_t    tmr_r;                     // Busy hold timer
   logic        settled_r;                 // Mode reached and stable
   logic        warm_r;                    // Next wake keeps context
   logic [3:0]  svc_cnt_r;                 // Interrupt servicing time left
   logic        mode_ready;                // Readiness of current mode
   logic        active;                    // Pads driven
   bic_flags_t  flags_r;                   // Sticky status flags
   bic_flags_t  clr_mask;                  // Flags to clear this cycle
   bic_flags_t  mask_r;                    // Source enables
   bic_flags_t  map_r [3];                 // Per pin routing
   bic_flags_t  snap_r;                    // Flags seen by the link
   logic        rfsw_en_r;                 // Pin 2 as RF switch
   logic        refosc_en_r;               // Pin 3 as oscillator supply
   logic [2:0]  irq_level;                 // Per pin interrupt request
   logic [2:0]  pin_val;                   // Per pin level in active modes
   logic [2:0]  pin_out_r;                 // Pin level flops
   logic [2:0]  pin_oe_n_r;                // Pin drive flops
   logic        busy_r;                    // Busy level flop
   logic        busy_oe_n_r;               // Busy drive flop

   // Two bytes, high first, into a flag vector
   function automatic bic_flags_t pick_flags(input int unsigned idx);
      return {frame_bytes[idx*8 +: `BIC_FLAG_HI_W], frame_bytes[(idx+1)*8 +: 8]};
   endfunction

   // ****************************************************************
   // Link front end on the shift clock
   // ****************************************************************
   bic_spi_link u_link (
      .sck         (sck),
      .nss_n       (nss_n),
      .mosi        (mosi),
      .status_snap (snap_r),
      .frame_bytes (frame_bytes),
      .frame_len   (frame_len),
      .miso_out    (miso_out),
      .miso_oe_n   (miso_oe_n)
   );

   // Flags offered to the link stay frozen while a frame runs
   always_ff @(posedge clk) begin
      if (reset) begin
         snap_r <= `BIC_FLAGS_RESET;
      end else if (nss_sync_r) begin
         snap_r <= flags_r;
      end
   end

   // ****************************************************************
   // Frame select synchroniser
   // ****************************************************************
   // Select is a pin, so two flops before anything looks at it
   always_ff @(posedge clk) begin
      if (reset) begin
         nss_meta_r <= 1'b1;
         nss_sync_r <= 1'b1;
         nss_prev_r <= 1'b1;
      end else begin
         nss_meta_r <= nss_n;
         nss_sync_r <= nss_meta_r;
         nss_prev_r <= nss_sync_r;
      end
   end

   assign frame_start = nss_prev_r & ~nss_sync_r;
   assign frame_end   = nss_sync_r & ~nss_prev_r;

   // ****************************************************************
   // Command decode
   // ****************************************************************
   // Frame bytes are quiet once select is high, so sampling at the
   // synced rise is safe; a frame with no bytes repeats the last command, as frame_len keeps its count
   assign opcode    = frame_bytes[7:0];
   assign cmd_valid = frame_end && frame_len != 4'h0 &&
                      mode_r != md_sleep && mode_r != md_startup;
   assign cmd_write = cmd_valid && opcode != `BIC_OP_READ_FLAGS;

   // ****************************************************************
   // Mode sequencing and busy timing
   // ****************************************************************
   // What each mode waits for before busy may drop
   always_comb begin
      unique case (mode_r)
         md_fsynth: mode_ready = pll_locked;
         md_rx:     mode_ready = rx_ready;
         md_tx:     mode_ready = pa_ramp_done;
         default:   mode_ready = 1'b1;
      endcase
   end

   // One process owns mode, timer and settle state so that a command and
   // a wake cannot race each other
   always_ff @(posedge clk) begin
      if (reset) begin
         mode_r    <= md_startup;
         tmr_r     <= 18'(COLD_START_CYC);
         settled_r <= 1'b0;
         warm_r    <= 1'b0;
      end else begin
         // Timer runs down in every mode
         if (tmr_r != `BIC_TMR_ZERO) begin
            tmr_r <= tmr_r - 18'h00001;
         end
         unique case (mode_r)
            md_startup: begin
               // Boot done: hand control to the standby state
               if (tmr_r == `BIC_TMR_ZERO) begin
                  mode_r    <= md_stby_rc;
                  settled_r <= 1'b1;
               end
            end
            md_sleep: begin
               // Wake on select low or timer end of count
               if (frame_start || wake_timer_eoc) begin
                  mode_r    <= md_startup;
                  tmr_r     <= warm_r ? 18'(WARM_START_CYC) : 18'(COLD_START_CYC);
                  settled_r <= 1'b0;
               end
            end
            md_stby_rc, md_stby_crystal_oscillator, md_fsynth, md_rx, md_tx: begin
               if (!settled_r && tmr_r == `BIC_TMR_ZERO && mode_ready) begin
                  settled_r <= 1'b1;
               end
               // Single-shot radio modes fall back to standby when done
               if (mode_r == md_tx && (event_pulse[`BIC_IRQ_TX_DONE] ||
                                       event_pulse[`BIC_IRQ_TIMEOUT])) begin
                  mode_r <= md_stby_rc;
               end
               if (mode_r == md_rx && (event_pulse[`BIC_IRQ_RX_DONE] ||
                                       event_pulse[`BIC_IRQ_TIMEOUT])) begin
                  mode_r <= md_stby_rc;
               end
               // A write command restarts the settle wait
               if (cmd_write) begin
                  settled_r <= 1'b0;
                  tmr_r     <= `BIC_CMD_CYC;
                  unique case (opcode)
                     `BIC_OP_SLEEP: begin
                        // Sleep only from RC standby; elsewhere just a write
                        if (mode_r == md_stby_rc) begin
                           mode_r <= md_sleep;
                           warm_r <= frame_bytes[8 + `BIC_SLEEP_WARM_BIT];
                        end
                     end
                     `BIC_OP_STANDBY: begin
                        if (frame_bytes[8 + `BIC_STBY_CRYSTAL_OSCILLATOR_BIT]) begin
                           mode_r <= md_stby_crystal_oscillator;
                           tmr_r  <= `BIC_CRYSTAL_OSCILLATOR_CYC;
                        end else begin
                           mode_r <= md_stby_rc;
                        end
                     end
                     `BIC_OP_FSYNTH: mode_r <= md_fsynth;
                     `BIC_OP_TX:     mode_r <= md_tx;
                     `BIC_OP_RX:     mode_r <= md_rx;
                     default: begin
                        // Parameter writes keep the mode
                     end
                  endcase
               end
            end
            default: begin
               // Unused code: recover through a cold boot
               mode_r    <= md_startup;
               tmr_r     <= 18'(COLD_START_CYC);
               settled_r <= 1'b0;
            end
         endcase
      end
   end

   // Internal interrupt servicing holds busy for a short while
   always_ff @(posedge clk) begin
      if (reset) begin
         svc_cnt_r <= 4'h0;
      end else if (active && event_pulse != `BIC_FLAGS_RESET) begin
         svc_cnt_r <= `BIC_SVC_CYC;
      end else if (svc_cnt_r != 4'h0) begin
         svc_cnt_r <= svc_cnt_r - 4'h1;
      end
   end

   // Pads and busy are driven only once boot is over and out of sleep
   assign active = mode_r != md_sleep && mode_r != md_startup;

   // Busy level and its drive; the first write edge already raises it,
   // about three core cycles after select rises
   always_ff @(posedge clk) begin
      if (reset) begin
         busy_r      <= 1'b1;
         busy_oe_n_r <= 1'b1;
      end else begin
         busy_r      <= !active || !settled_r ||
                        cmd_write ||
                        svc_cnt_r != 4'h0;
         busy_oe_n_r <= !active;
      end
   end

   // ****************************************************************
   // Status flags and routing
   // ****************************************************************
   // Bits chosen for clearing by a clear command
   always_comb begin
      clr_mask = `BIC_FLAGS_RESET;
      if (cmd_valid && opcode == `BIC_OP_CLEAR_FLAGS) begin
         clr_mask = pick_flags(1);
      end
   end

   // Sticky flags; a new event wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         flags_r <= `BIC_FLAGS_RESET;
      end else begin
         flags_r <= (flags_r & ~clr_mask) | event_pulse;
      end
   end

   // Enables, routing and alternate pin functions
   always_ff @(posedge clk) begin
      if (reset) begin
         mask_r      <= `BIC_FLAGS_RESET;
         map_r[0]    <= `BIC_FLAGS_RESET;
         map_r[1]    <= `BIC_FLAGS_RESET;
         map_r[2]    <= `BIC_FLAGS_RESET;
         rfsw_en_r   <= 1'b0;
         refosc_en_r <= 1'b0;
      end else if (cmd_valid) begin
         if (opcode == `BIC_OP_MASK_MAP) begin
            mask_r   <= pick_flags(1);
            map_r[0] <= pick_flags(3);
            map_r[1] <= pick_flags(5);
            map_r[2] <= pick_flags(7);
         end
         if (opcode == `BIC_OP_RFSW_EN) begin
            rfsw_en_r <= frame_bytes[8 + `BIC_ENABLE_BIT];
         end
         if (opcode == `BIC_OP_REFOSC_EN) begin
            refosc_en_r <= frame_bytes[8 + `BIC_ENABLE_BIT];
         end
      end
   end

   // ****************************************************************
   // Output pins
   // ****************************************************************
   // Alternate functions override the interrupt on pins 2 and 3
   always_comb begin
      pin_val[0] = irq_level[0];
      // Switch follows transmit only
      pin_val[1] = rfsw_en_r ? (mode_r == md_tx) : irq_level[1];
      // Oscillator supply on whenever the crystal path is in use
      pin_val[2] = refosc_en_r ? (mode_r == md_stby_crystal_oscillator || mode_r == md_fsynth ||
                                  mode_r == md_rx || mode_r == md_tx) : irq_level[2];
   end

   // Same request, drive and register for each of the three pins
   for (genvar i = 0; i < 3; i++) begin : g_pin
      assign irq_level[i] = |(flags_r & mask_r & map_r[i]);
      always_ff @(posedge clk) begin
         if (reset) begin
            pin_out_r[i]  <= 1'b0;
            pin_oe_n_r[i] <= 1'b1;
         end else begin
            pin_out_r[i]  <= active & pin_val[i];
            pin_oe_n_r[i] <= !active;
         end
      end
   end

   assign busy_out                 = busy_r;
   assign busy_oe_n                = busy_oe_n_r;
   assign irq_pin_primary_out      = pin_out_r[0];
   assign irq_pin_primary_oe_n     = pin_oe_n_r[0];
   assign irq_or_rfswitch_pin_out  = pin_out_r[1];
   assign irq_or_rfswitch_pin_oe_n = pin_oe_n_r[1];
   assign irq_or_refosc_pin_out    = pin_out_r[2];
   assign irq_or_refosc_pin_oe_n   = pin_oe_n_r[2];
   assign chip_mode                = mode_r;
endmodule // bic_busy_irq_ctrl

/* sim/bic_host_model.sv */
// Host model: frames on select, shift clock and data
`timescale 1ns/1ps
module bic_host_model (
   output logic     sck = 0,   // Still between frames
   output logic     nss_n = 1, // Frame select
   output logic     mosi = 0,  // Data to device
   input wire logic miso_out,  // Reply data
   input wire logic busy_out   // Device busy
);
   logic [71:0] rx = 72'h0; // Reply bits, newest low
   // Sends n bytes from the top of d, MSB first
   task automatic frame(input logic [71:0] d, input int n);
      wait (busy_out === 1'b0);
      #5 nss_n = 0; // Off the core clock edge
      #40;
      for (int i = 0; i < n * 8; i++) begin
         mosi = d[71 - i];
         #16 sck = 1;
         rx = {rx[70:0], miso_out};
         #16 sck = 0;
      end
      #40 nss_n = 1;
      mosi = ~mosi; // Released line keeps no stale level
      #200;
   endtask
endmodule // bic_host_model

/* sim/bic_busy_irq_ctrl_checker.sv */
// Checker of busy, mode and pin behaviour
`timescale 1ns/1ps
module bic_busy_irq_ctrl_checker import bic_pkg::*; #(
   parameter int unsigned COLD_START_CYC = 20, // Cold wake time
   parameter int unsigned WARM_START_CYC = 10  // Warm wake time
) (
   input wire logic clk, reset, pll_locked, rx_ready, pa_ramp_done, busy_out, busy_oe_n,
   input wire logic irq_pin_primary_out, irq_pin_primary_oe_n, irq_or_rfswitch_pin_out,
   input wire bic_pkg::bic_flags_t event_pulse, // Radio events
   input wire bic_pkg::bic_mode_e  chip_mode    // Current mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_start_busy_high: assert property (chip_mode == md_startup |-> busy_out)
      else $error("busy low in startup");
   a_sleep_pads_float: assert property ($past(chip_mode) == md_sleep && chip_mode == md_sleep
      |-> busy_out && busy_oe_n && irq_pin_primary_oe_n && !irq_pin_primary_out) else $error("pads in sleep");
   a_fs_wait_lock: assert property (chip_mode == md_fsynth && !pll_locked |=> busy_out)
      else $error("busy low before lock");
   a_rx_wait_ready: assert property (chip_mode == md_rx && !rx_ready |=> busy_out)
      else $error("busy low before receiver ready");
   a_tx_wait_ramp: assert property (chip_mode == md_tx && !pa_ramp_done |=> busy_out)
      else $error("busy low before ramp");
   a_event_service: assert property (|event_pulse && chip_mode > md_sleep |-> ##2 busy_out [*6])
      else $error("event not serviced");
   a_busy_fall_mode: assert property ($fell(busy_out) |-> chip_mode > md_sleep)
      else $error("busy fell while inactive");
   a_rfswitch_tx_only: assert property (irq_or_rfswitch_pin_out |-> chip_mode == md_tx || $past(chip_mode) == md_tx)
      else $error("switch high outside transmit");
   c_tx: cover property (chip_mode == md_tx && !busy_out);
   c_sleep: cover property (chip_mode == md_sleep);
   c_event: cover property (|event_pulse && busy_out);
endmodule // bic_busy_irq_ctrl_checker
bind bic_busy_irq_ctrl bic_busy_irq_ctrl_checker #(.COLD_START_CYC(COLD_START_CYC), .WARM_START_CYC(WARM_START_CYC))
   chk_i (.clk(clk), .reset(reset), .pll_locked(pll_locked), .rx_ready(rx_ready), .pa_ramp_done(pa_ramp_done),
   .busy_out(busy_out), .busy_oe_n(busy_oe_n), .irq_pin_primary_out(irq_pin_primary_out),
   .irq_pin_primary_oe_n(irq_pin_primary_oe_n), .irq_or_rfswitch_pin_out(irq_or_rfswitch_pin_out),
   .event_pulse(event_pulse), .chip_mode(chip_mode));

/* sim/tb_bic_busy_irq_ctrl.sv */
// Bench of the busy and interrupt pin control block
`timescale 1ns/1ps
module tb_bic_busy_irq_ctrl;
   import bic_pkg::*;
   logic clk = 0, reset = 1, wake = 0;             // Clock, reset, wake timer
   logic [2:0] rdy = 3'h0;                         // Lock, receiver, ramp
   bic_flags_t ev = 10'h000;                       // Event pulses
   wire sck, nss_n, mosi, miso, busy, boe, p1, p2, p3, moe; // Pins
   bic_mode_e mode;                                // Current mode
   int errors = 0, checks_done = 0, cyc = 0;       // Tallies
   // Rows: mask, events, pin 1 level
   logic [20:0] rows [0:4] = '{{10'h3FF, 10'h001, 1'b1}, {10'h3FF, 10'h200, 1'b1},
      {10'h1FF, 10'h200, 1'b0}, {10'h040, 10'h040, 1'b1}, {10'h001, 10'h3FE, 1'b0}};
   logic [7:0] ops [0:2] = '{8'h17, 8'h19, 8'h18}; // Synthesis, receive, transmit
   always #12.5 clk = ~clk;
   bic_host_model host (.sck(sck), .nss_n(nss_n), .mosi(mosi), .miso_out(miso), .busy_out(busy));
   bic_busy_irq_ctrl #(.COLD_START_CYC(20), .WARM_START_CYC(10)) dut (.clk(clk), .reset(reset), .sck(sck),
      .nss_n(nss_n), .mosi(mosi), .event_pulse(ev), .pll_locked(rdy[0]), .rx_ready(rdy[1]),
      .pa_ramp_done(rdy[2]), .wake_timer_eoc(wake), .miso_out(miso), .miso_oe_n(moe), .busy_out(busy),
      .busy_oe_n(boe), .irq_pin_primary_out(p1), .irq_pin_primary_oe_n(), .irq_or_rfswitch_pin_out(p2),
      .irq_or_rfswitch_pin_oe_n(), .irq_or_refosc_pin_out(p3), .irq_or_refosc_pin_oe_n(), .chip_mode(mode));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Waits n edges, then steps off the edge
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard, well above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      wait_clk(2);
      reset = 0;
      chk(busy, 1);
      wait_clk(40);
      for (int i = 0; i < 5; i++) begin
         host.frame({8'h12, 6'h0, rows[i][20:11], 16'h03FF, 32'h0}, 9);
         wait_clk(1);
         ev = rows[i][10:1];
         wait_clk(1);
         ev = 10'h000;
         wait_clk(20);
         chk(p1, rows[i][0]);
         host.frame({8'h10, 64'h0}, 3);
         chk(host.rx[15:0], {6'h0, rows[i][10:1]});
         chk({busy, moe}, 2'b01);
         host.frame({8'h11, 16'h03FF, 48'h0}, 3);
         wait_clk(20);
         chk(p1, 0);
      end
      // Mode chain with late readiness, switch pin enabled
      host.frame({8'h13, 8'h01, 56'h0}, 2);
      host.frame({8'h14, 8'h01, 56'h0}, 2);
      for (int i = 0; i < 3; i++) begin
         host.frame({ops[i], 64'h0}, 1);
         chk(busy, 1);
         wait_clk(30);
         chk(busy, 1);
         rdy[i] = 1;
         wait_clk(10);
         chk(busy, 0);
      end
      chk(p2, 1);
      chk(p3, 1);
      ev = 10'h001;
      wait_clk(1);
      ev = 10'h000;
      wait_clk(20);
      chk(mode, md_stby_rc);
      chk(p2, 0);
      chk(p3, 0);
      host.frame({8'h15, 8'h04, 56'h0}, 2);
      chk(mode, md_sleep);
      chk({busy, boe}, 2'b11);
      wait_clk(1);
      wake = 1;
      wait_clk(1);
      wake = 0;
      wait_clk(15); // Warm wake is 10 cycles, cold would be 20
      chk(mode, md_stby_rc);
      chk(busy, 0);
      // Reset again in mid-run, with pin 1 raised
      reset = 1;
      wait_clk(2);
      reset = 0;
      chk({busy, boe, p1, mode}, {3'b110, md_startup});
      wait_clk(40);
      chk(busy, 0);
      tally_and_finish();
   end
endmodule // tb_bic_busy_irq_ctrl
